/* rtl/gtl_regs_pkg.sv */
/*
 * Shared constants of the GPIB talker/listener register bank: register
 * indices, field positions, auxiliary selectors, commands, reset values
 * and the settling time.
 * Assumes an AXI4-Lite master with 8-bit byte addresses and 32-bit data.
 */
package gtl_regs_pkg;
   // ************************************************************
   // Bus and register map (byte address is four times the index)
   // ************************************************************
   localparam int AXI_AW = 8;
   localparam logic [5:0] IDX_ADDR_STATE = 6'h04;
   localparam logic [5:0] IDX_AUX = 6'h05;
   localparam logic [5:0] IDX_DEV_ADDR = 6'h06;
   localparam logic [5:0] IDX_EOS = 6'h07;
   localparam logic [5:0] IDX_CTRL = 6'h08;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int ADDRESS_REG_SELECTOR_BIT = 7;
   localparam int DISABLE_TALKER_BIT = 6;
   localparam int DISABLE_LISTENER_BIT = 5;
   localparam int EOI_LATCH_BIT = 7;
   localparam int HOLD_END_EOS_BIT = 2;
   localparam int EOI_ON_EOS_BIT = 3;
   localparam int EOS_WIDTH_BIT = 4;
   localparam int PP_DISABLE_BIT = 4;
   localparam int PP_SENSE_BIT = 3;
   // ************************************************************
   // Auxiliary selectors and immediate commands
   // ************************************************************
   localparam logic [2:0] SEL_CMD = 3'h0;
   localparam logic [2:0] SEL_PP = 3'h3;
   localparam logic [2:0] SEL_A = 3'h4;
   localparam logic [2:0] SEL_B = 3'h5;
   localparam logic [2:0] SEL_E = 3'h6;
   localparam logic [4:0] CMD_PON = 5'h00;
   localparam logic [4:0] CMD_PPF_CLR = 5'h01;
   localparam logic [4:0] CMD_CHIP_RESET = 5'h02;
   localparam logic [4:0] CMD_FINISH_HS = 5'h03;
   localparam logic [4:0] CMD_TRIGGER = 5'h04;
   localparam logic [4:0] CMD_RTL_OFF = 5'h05;
   localparam logic [4:0] CMD_SEND_EOI = 5'h06;
   localparam logic [4:0] CMD_NOT_VALID = 5'h07;
   localparam logic [4:0] CMD_PPF_SET = 5'h09;
   localparam logic [4:0] CMD_RTL_ON = 5'h0D;
   localparam logic [4:0] CMD_VALID = 5'h0F;
   localparam logic [4:0] CMD_LISTEN = 5'h13;
   localparam logic [4:0] CMD_LISTEN_CONT = 5'h1B;
   localparam logic [4:0] CMD_UNLISTEN = 5'h1C;
   localparam logic [1:0] HS_CONTINUOUS = 2'h3;
   // ************************************************************
   // Reset values and timing
   // ************************************************************
   localparam logic PON_RESET = 1'b1;
   localparam int CLK_PERIOD_NS = 100;
   localparam int T1_FAST_NS = 500;
   localparam logic [3:0] T1_FAST_CYCLES = 4'((T1_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

/* rtl/gpib_talker_listener_regs.sv */
/*
 * Register bank and auxiliary command decoder of a GPIB talker/listener,
 * reached over AXI4-Lite.
 * Assumes the interface functions outside report their states and events
 * as inputs synchronous to CLK, and consume the modes and pulses driven here.
 */
// Added by the designer: the AXI4-Lite register port.
// Operation
// - Mode 3: two primaries, host qualifies secondary
// - Talker/listener/major-minor change raises enabled event
// - Serial poll state: set enable, clear disable/clear
// - Major-minor flag follows which address matched
// - Address write selects register by top bit
// - Disable bits gate talk/listen match, read back
// - EOI level latched with each received byte
// - Passthrough read returns live data lines
// - End-of-string compared on seven or eight bits
// - Auxiliary writes routed by top three bits
// - Power-on toggles; chip reset sets, clears all
// - Finish handshake releases ready-for-data holdoff
// - Trigger pulse from command or group trigger
// - Return-to-local set, or reset with pulse
// - Send END with next byte while talking
// - Valid/not valid resume held secondary address
// - Poll flag from C3; B4 picks source
// - Listen pulses, continuous mode on/off, unlisten
// - Local poll answers selected line when matching
// - Register A: handshake mode and end-of-string
// - Register B: passthrough, END, settling, source
// - Register E: holdoff on clear or trigger
module gpib_talker_listener_regs
(
   input wire logic CLK, // 10 MHz clock
   input wire logic RST, // Asynchronous reset, active high
   input wire logic [gtl_regs_pkg::AXI_AW-1:0] S_AXI_AWADDR, // Write address
   input wire logic S_AXI_AWVALID, // Write address valid
   output logic S_AXI_AWREADY, // Write address ready
   input wire logic [31:0] S_AXI_WDATA, // Write data
   input wire logic [3:0] S_AXI_WSTRB, // Byte enables
   input wire logic S_AXI_WVALID, // Write data valid
   output logic S_AXI_WREADY, // Write data ready
   output logic [1:0] S_AXI_BRESP, // Write response
   output logic S_AXI_BVALID, // Write response valid
   input wire logic S_AXI_BREADY, // Write response ready
   input wire logic [gtl_regs_pkg::AXI_AW-1:0] S_AXI_ARADDR, // Read address
   input wire logic S_AXI_ARVALID, // Read address valid
   output logic S_AXI_ARREADY, // Read address ready
   output logic [31:0] S_AXI_RDATA, // Read data
   output logic [1:0] S_AXI_RRESP, // Read response
   output logic S_AXI_RVALID, // Read data valid
   input wire logic S_AXI_RREADY, // Read data ready
   input wire logic TALKER_ADDRESSED, // Talker addressed state
   input wire logic LISTENER_ADDRESSED, // Listener addressed state
   input wire logic TALK_PRIMARY, // Talker primary addressed state
   input wire logic LISTEN_PRIMARY, // Listener primary addressed state
   input wire logic SPOLL_ENABLE_RX, // Serial poll enable received
   input wire logic SPOLL_DISABLE_RX, // Serial poll disable received
   input wire logic IFC_RX, // Interface clear received
   input wire logic ADDR_RX, // Primary talk/listen address received
   input wire logic ADDR_RX_LISTEN, // Received address is a listen address
   input wire logic [4:0] ADDR_RX_CODE, // Received 5-bit address
   input wire logic [7:0] DIO, // Current GPIB data lines
   input wire logic EOI_LINE, // Current EOI line level
   input wire logic DATA_IN_STROBE, // Byte taken into data-in register
   input wire logic GET_RX, // Device trigger active state entered
   input wire logic TACS_STATE, // Talker active state
   input wire logic BYTE_OUT_WR, // Byte written for output
   input wire logic LIDS_STATE, // Listener idle state
   input wire logic SRQS_STATE, // Service request state
   output logic PON, // Power-on message
   output logic TALK_MATCH, // My talk address seen
   output logic LISTEN_MATCH, // My listen address seen
   output logic ADDR_STATUS_CHANGE_IRQ, // Address state change event
   output logic EOS_END, // End-of-string byte received, END enabled
   output logic EOS_SEND_EOI, // Send EOI with end-of-string
   output logic [1:0] HS_MODE, // Effective handshake mode
   output logic FINISH_HS, // Release ready-for-data holdoff
   output logic TRIGGER_PULSE_OUT, // Trigger pulse
   output logic RTL_MSG, // Return-to-local level
   output logic RTL_PULSE, // Return-to-local pulse
   output logic SEND_EOI_NEXT, // Next output byte carries END
   output logic SEC_VALID, // Held secondary address valid
   output logic SEC_NOT_VALID, // Held secondary address not valid
   output logic LTN_PULSE, // Local listen message
   output logic LUN_PULSE, // Local unlisten message
   output logic IST_MSG, // Individual status
   output logic [7:0] PP_RESPONSE, // Local parallel poll line drive
   output logic UNKNOWN_PASS, // Hold and pass unknown commands
   output logic SPOLL_END, // Send END with status byte
   output logic [3:0] T1_SETTLE_CYCLES, // Short settling, 0 for standard
   output logic DAC_HOLD_DCL, // Holdoff on device clear
   output logic DAC_HOLD_GET // Holdoff on group trigger
);
   import gtl_regs_pkg::*;

   // ************************************************************
   // AXI4-Lite slave
   // ************************************************************
   logic aw_held, w_held, wstrb_lo, do_write, wr_en, wr_mapped, rd_mapped;
   logic [5:0] wr_idx;
   logic [7:0] wdata_q, rd_byte;
   logic [AXI_AW-1:0] awaddr_q;
   logic [6:0] addr0, addr1;
   logic [7:0] eos_code;
   logic [4:0] mode_a, pp_setup;
   logic [3:0] mode_b;
   logic [1:0] mode_e;
   logic addr_status_change_irq_en, serial_poll_mode_state, major_minor_flag, la_q, ta_q, lpas_q, tpas_q, eoi_q, pp_flag, cont;
   logic [2:0] prev_state;

   assign do_write = aw_held && w_held && !S_AXI_BVALID;
   assign wr_idx = awaddr_q[AXI_AW-1:2];
   assign wr_en = do_write && wstrb_lo;
   assign wr_mapped = wr_idx >= IDX_ADDR_STATE && wr_idx <= IDX_CTRL;

   // Address and data are taken in either order, released by the write
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= 8'h00;
         wstrb_lo <= 1'b0;
         S_AXI_AWREADY <= 1'b1;
         S_AXI_WREADY <= 1'b1;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= RESP_OKAY;
      end
      else
      begin
         if (S_AXI_AWVALID && S_AXI_AWREADY)
         begin
            aw_held <= 1'b1;
            awaddr_q <= S_AXI_AWADDR;
            S_AXI_AWREADY <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY)
         begin
            w_held <= 1'b1;
            wdata_q <= S_AXI_WDATA[7:0];
            wstrb_lo <= S_AXI_WSTRB[0];
            S_AXI_WREADY <= 1'b0;
         end
         if (do_write)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end
         else if (S_AXI_BVALID && S_AXI_BREADY)
            S_AXI_BVALID <= 1'b0;
      end
   end

   // Read multiplexer; the passthrough view shows the live data lines
   always_comb
   begin
      rd_mapped = 1'b1;
      case (S_AXI_ARADDR[AXI_AW-1:2])
         IDX_ADDR_STATE: rd_byte = {2'b00, serial_poll_mode_state, lpas_q, tpas_q, la_q, ta_q, major_minor_flag};
         IDX_AUX: rd_byte = DIO;
         IDX_DEV_ADDR: rd_byte = {1'b0, addr0};
         IDX_EOS: rd_byte = {eoi_q, addr1};
         IDX_CTRL: rd_byte = {7'h00, addr_status_change_irq_en};
         default:
         begin
            rd_byte = 8'h00;
            rd_mapped = 1'b0;
         end
      endcase
   end

   // Read channel answers one cycle after the address is taken
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         S_AXI_ARREADY <= 1'b1;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h00000000;
         S_AXI_RRESP <= RESP_OKAY;
      end
      else if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= {24'h000000, rd_byte};
         S_AXI_RRESP <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
      begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_ARREADY <= 1'b1;
      end
   end

   // ************************************************************
   // Auxiliary decode and mode registers
   // ************************************************************
   logic aux_wr, is_cmd, chip_clear;
   logic [4:0] cmd;
   assign aux_wr = wr_en && wr_idx == IDX_AUX;
   assign is_cmd = aux_wr && wdata_q[7:5] == SEL_CMD;
   assign cmd = wdata_q[4:0];
   assign chip_clear = is_cmd && cmd == CMD_CHIP_RESET;

   // Mode registers; unknown selectors change nothing
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         mode_a <= 5'h00;
         mode_b <= 4'h0;
         mode_e <= 2'h0;
         pp_setup <= 5'h00;
      end
      else if (chip_clear)
      begin
         mode_a <= 5'h00;
         mode_b <= 4'h0;
         mode_e <= 2'h0;
         pp_setup <= 5'h00;
      end
      else if (aux_wr)
      begin
         case (wdata_q[7:5])
            SEL_PP: pp_setup <= wdata_q[4:0];
            SEL_A: mode_a <= wdata_q[4:0];
            SEL_B: mode_b <= {wdata_q[4], wdata_q[2:0]};
            SEL_E: mode_e <= wdata_q[1:0];
            default: ;
         endcase
      end
   end

   // Device addresses, end-of-string code and event enable
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         addr0 <= 7'h00;
         addr1 <= 7'h00;
         eos_code <= 8'h00;
         addr_status_change_irq_en <= 1'b0;
      end
      else if (chip_clear)
      begin
         addr0 <= 7'h00;
         addr1 <= 7'h00;
         eos_code <= 8'h00;
         addr_status_change_irq_en <= 1'b0;
      end
      else if (wr_en)
      begin
         if (wr_idx == IDX_DEV_ADDR && !wdata_q[ADDRESS_REG_SELECTOR_BIT])
            addr0 <= wdata_q[6:0];
         if (wr_idx == IDX_DEV_ADDR && wdata_q[ADDRESS_REG_SELECTOR_BIT])
            addr1 <= wdata_q[6:0];
         if (wr_idx == IDX_EOS)
            eos_code <= wdata_q;
         if (wr_idx == IDX_CTRL)
            addr_status_change_irq_en <= wdata_q[0];
      end
   end

   // ************************************************************
   // Immediate commands
   // ************************************************************
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         PON <= PON_RESET;
         RTL_MSG <= 1'b0;
         cont <= 1'b0;
         pp_flag <= 1'b0;
         SEND_EOI_NEXT <= 1'b0;
         FINISH_HS <= 1'b0;
         TRIGGER_PULSE_OUT <= 1'b0;
         RTL_PULSE <= 1'b0;
         SEC_VALID <= 1'b0;
         SEC_NOT_VALID <= 1'b0;
         LTN_PULSE <= 1'b0;
         LUN_PULSE <= 1'b0;
      end
      else
      begin
         FINISH_HS <= is_cmd && cmd == CMD_FINISH_HS;
         TRIGGER_PULSE_OUT <= (is_cmd && cmd == CMD_TRIGGER) || GET_RX;
         RTL_PULSE <= is_cmd && cmd == CMD_RTL_OFF;
         SEC_VALID <= is_cmd && cmd == CMD_VALID;
         SEC_NOT_VALID <= is_cmd && cmd == CMD_NOT_VALID;
         LTN_PULSE <= is_cmd && (cmd == CMD_LISTEN || cmd == CMD_LISTEN_CONT);
         LUN_PULSE <= is_cmd && cmd == CMD_UNLISTEN;
         if (BYTE_OUT_WR)
            SEND_EOI_NEXT <= 1'b0;
         if (LIDS_STATE)
            cont <= 1'b0;
         if (is_cmd)
         begin
            case (cmd)
               CMD_PON: PON <= !PON;
               CMD_CHIP_RESET:
               begin
                  PON <= 1'b1;
                  RTL_MSG <= 1'b0;
                  cont <= 1'b0;
                  pp_flag <= 1'b0;
                  SEND_EOI_NEXT <= 1'b0;
               end
               CMD_RTL_ON: RTL_MSG <= 1'b1;
               CMD_RTL_OFF: RTL_MSG <= 1'b0;
               CMD_SEND_EOI: SEND_EOI_NEXT <= TACS_STATE || SEND_EOI_NEXT;
               CMD_PPF_SET: pp_flag <= 1'b1;
               CMD_PPF_CLR: pp_flag <= 1'b0;
               CMD_LISTEN: cont <= 1'b0;
               CMD_LISTEN_CONT: cont <= 1'b1;
               default: ;
            endcase
         end
      end
   end

   // ************************************************************
   // Address status and matching
   // ************************************************************
   logic hit0, hit1;
   assign hit0 = ADDR_RX_CODE == addr0[4:0] &&
      !(ADDR_RX_LISTEN ? addr0[DISABLE_LISTENER_BIT] : addr0[DISABLE_TALKER_BIT]);
   assign hit1 = ADDR_RX_CODE == addr1[4:0] &&
      !(ADDR_RX_LISTEN ? addr1[DISABLE_LISTENER_BIT] : addr1[DISABLE_TALKER_BIT]);

   // State view, major/minor tracking and change event
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         la_q <= 1'b0;
         ta_q <= 1'b0;
         lpas_q <= 1'b0;
         tpas_q <= 1'b0;
         serial_poll_mode_state <= 1'b0;
         major_minor_flag <= 1'b0;
         prev_state <= 3'h0;
         ADDR_STATUS_CHANGE_IRQ <= 1'b0;
         TALK_MATCH <= 1'b0;
         LISTEN_MATCH <= 1'b0;
      end
      else
      begin
         la_q <= LISTENER_ADDRESSED;
         ta_q <= TALKER_ADDRESSED;
         lpas_q <= LISTEN_PRIMARY;
         tpas_q <= TALK_PRIMARY;
         if (SPOLL_DISABLE_RX || IFC_RX || chip_clear)
            serial_poll_mode_state <= 1'b0;
         else if (SPOLL_ENABLE_RX)
            serial_poll_mode_state <= 1'b1;
         if (chip_clear)
            major_minor_flag <= 1'b0;
         else if (ADDR_RX && !PON && hit1)
            major_minor_flag <= 1'b1;
         else if (ADDR_RX && !PON && hit0)
            major_minor_flag <= 1'b0;
         TALK_MATCH <= ADDR_RX && !PON && !ADDR_RX_LISTEN && (hit0 || hit1);
         LISTEN_MATCH <= ADDR_RX && !PON && ADDR_RX_LISTEN && (hit0 || hit1);
         prev_state <= {la_q, ta_q, major_minor_flag};
         ADDR_STATUS_CHANGE_IRQ <= addr_status_change_irq_en && prev_state != {la_q, ta_q, major_minor_flag};
      end
   end

   // ************************************************************
   // Received byte: EOI latch and end-of-string compare
   // ************************************************************
   logic eos_eq;
   assign eos_eq = mode_a[EOS_WIDTH_BIT] ? DIO == eos_code : DIO[6:0] == eos_code[6:0];

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         eoi_q <= 1'b0;
         EOS_END <= 1'b0;
      end
      else
      begin
         if (chip_clear)
            eoi_q <= 1'b0;
         else if (DATA_IN_STROBE)
            eoi_q <= EOI_LINE;
         EOS_END <= DATA_IN_STROBE && mode_a[HOLD_END_EOS_BIT] && eos_eq;
      end
   end

   // ************************************************************
   // Mode outputs and local parallel poll answer
   // ************************************************************
   logic ist;
   assign ist = mode_b[3] ? SRQS_STATE : pp_flag;

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         HS_MODE <= 2'h0;
         EOS_SEND_EOI <= 1'b0;
         UNKNOWN_PASS <= 1'b0;
         SPOLL_END <= 1'b0;
         T1_SETTLE_CYCLES <= 4'h0;
         DAC_HOLD_DCL <= 1'b0;
         DAC_HOLD_GET <= 1'b0;
         IST_MSG <= 1'b0;
         PP_RESPONSE <= 8'h00;
      end
      else
      begin
         HS_MODE <= cont ? HS_CONTINUOUS : mode_a[1:0];
         EOS_SEND_EOI <= mode_a[EOI_ON_EOS_BIT];
         UNKNOWN_PASS <= mode_b[0];
         SPOLL_END <= mode_b[1];
         T1_SETTLE_CYCLES <= mode_b[2] ? T1_FAST_CYCLES : 4'h0;
         DAC_HOLD_DCL <= mode_e[0];
         DAC_HOLD_GET <= mode_e[1];
         IST_MSG <= ist;
         if (!PON && !pp_setup[PP_DISABLE_BIT] && ist == pp_setup[PP_SENSE_BIT])
            PP_RESPONSE <= 8'h01 << pp_setup[2:0];
         else
            PP_RESPONSE <= 8'h00;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   AST_SERIAL_POLL_SET: assert property (@(posedge CLK) disable iff (RST)
      SPOLL_ENABLE_RX && !SPOLL_DISABLE_RX && !IFC_RX && !chip_clear |=> serial_poll_mode_state)
      else $error("serial poll state not set");
   AST_SERIAL_POLL_CLR: assert property (@(posedge CLK) disable iff (RST)
      SPOLL_DISABLE_RX || IFC_RX |=> !serial_poll_mode_state)
      else $error("serial poll state not cleared");
   AST_MAJOR_MINOR: assert property (@(posedge CLK) disable iff (RST)
      ADDR_RX && !PON && hit1 && !chip_clear |=> major_minor_flag)
      else $error("major/minor flag not set on second address");
   AST_STATE_CHANGE: assert property (@(posedge CLK) disable iff (RST)
      addr_status_change_irq_en && ($changed(la_q) || $changed(ta_q)) |=> ADDR_STATUS_CHANGE_IRQ)
      else $error("address state change not flagged");
   AST_ADDR_WRITE: assert property (@(posedge CLK) disable iff (RST)
      wr_en && wr_idx == IDX_DEV_ADDR && !wdata_q[7] |=> addr0 == $past(wdata_q[6:0]) && $stable(addr1))
      else $error("address register 0 write wrong");
   AST_TALK_DISABLED: assert property (@(posedge CLK) disable iff (RST)
      ADDR_RX && !ADDR_RX_LISTEN && ADDR_RX_CODE == addr0[4:0] && addr0[6] && !hit1 |=> !TALK_MATCH)
      else $error("talk match despite disable");
   AST_EOI_LATCH: assert property (@(posedge CLK) disable iff (RST)
      DATA_IN_STROBE && !chip_clear |=> eoi_q == $past(EOI_LINE))
      else $error("EOI level not latched");
   AST_EOS_END: assert property (@(posedge CLK) disable iff (RST)
      DATA_IN_STROBE && mode_a[2] && !mode_a[4] && DIO[6:0] == eos_code[6:0] |=> EOS_END)
      else $error("seven-bit end-of-string missed");
   AST_PON_TOGGLE: assert property (@(posedge CLK) disable iff (RST)
      is_cmd && cmd == CMD_PON |=> PON != $past(PON))
      else $error("power-on message not toggled");
   AST_TRIGGER: assert property (@(posedge CLK) disable iff (RST)
      GET_RX |=> TRIGGER_PULSE_OUT)
      else $error("no trigger pulse on group trigger");
   AST_POLL_LINE: assert property (@(posedge CLK) disable iff (RST)
      !PON && pp_setup[4] |=> PP_RESPONSE == 8'h00)
      else $error("poll answer while disabled");
   AST_UNDEFINED: assert property (@(posedge CLK) disable iff (RST)
      aux_wr && (wdata_q[7:5] == 3'h7 || wdata_q[7:5] == 3'h1 || wdata_q[7:5] == 3'h2)
      |=> $stable(mode_a) && $stable(mode_b) && $stable(mode_e) && $stable(pp_setup))
      else $error("undefined selector changed state");
endmodule // gpib_talker_listener_regs

/* sim/gtl_bus_side.sv */
/* Far-side bus model: data lines, EOI, byte strobe, trigger event.
   Assumes its tasks are called right after a rising CLK edge. */
module gtl_bus_side
(
   input wire logic CLK, // Clock
   output logic [7:0] DIO = 8'h00, // Data lines
   output logic EOI_LINE = 1'h0, // EOI level
   output logic DATA_IN_STROBE = 1'h0, // Byte taken
   output logic GET_RX = 1'h0 // Trigger entered
);
   timeunit 1ns;
   timeprecision 1ns;
   // One byte for a cycle, then released lines show its inverse
   task automatic put_byte(input logic [7:0] d, input logic e);
      DIO <= d;
      EOI_LINE <= e;
      DATA_IN_STROBE <= 1'h1;
      @(posedge CLK);
      DIO <= ~d;
      EOI_LINE <= ~e;
      DATA_IN_STROBE <= 1'h0;
   endtask
   // One-cycle trigger event
   task automatic pulse_trigger;
      GET_RX <= 1'h1;
      @(posedge CLK);
      GET_RX <= 1'h0;
   endtask
endmodule // gtl_bus_side

/* sim/tb_gpib_talker_listener_regs.sv */
/* Bench for the register bank: table of register cases, then modes and events.
   Assumes gtl_bus_side drives the data lines, EOI and trigger. */
module tb_gpib_talker_listener_regs import gtl_regs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK = 1'h0, RST = 1'h1, S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h1;
   logic S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h1, TALKER_ADDRESSED = '0, LISTENER_ADDRESSED = '0;
   logic TALK_PRIMARY = '0, LISTEN_PRIMARY = '0, SPOLL_ENABLE_RX = '0, SPOLL_DISABLE_RX = '0, IFC_RX = '0;
   logic ADDR_RX = '0, ADDR_RX_LISTEN = '0, TACS_STATE = '0, BYTE_OUT_WR = '0, LIDS_STATE = '0, SRQS_STATE = '0;
   logic [7:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0, DIO, q, PP_RESPONSE;
   logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA;
   logic [4:0] ADDR_RX_CODE = '0;
   logic [3:0] S_AXI_WSTRB = 4'hF, T1_SETTLE_CYCLES;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP, HS_MODE, r;
   logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, PON, TALK_MATCH, LISTEN_MATCH;
   logic ADDR_STATUS_CHANGE_IRQ, EOS_END, EOS_SEND_EOI, FINISH_HS, TRIGGER_PULSE_OUT, RTL_MSG, RTL_PULSE;
   logic SEND_EOI_NEXT, SEC_VALID, SEC_NOT_VALID, LTN_PULSE, LUN_PULSE, IST_MSG, UNKNOWN_PASS, SPOLL_END;
   logic DAC_HOLD_DCL, DAC_HOLD_GET, EOI_LINE, DATA_IN_STROBE, GET_RX;
   int n_mismatch = 0, cmp_count = 0, cyc = 0, n_trig = 0;
   logic [8:0] seen = '0;
   // Auxiliary writes of the command scenario
   logic [7:0] cmds [12] = '{8'h7A, 8'h03, 8'h05, 8'h0D, 8'h0F, 8'h07, 8'h1B, 8'h1C, 8'h04, 8'h9E, 8'h6A, 8'h06};
   // Write address, write byte, read address, expected byte
   logic [31:0] rows [5] = '{32'h1825_1825, 32'h18C3_1C43, 32'h187F_187F, 32'h10FF_1000, 32'h143F_187F};
   gpib_talker_listener_regs gpib_talker_listener_regs_i (.*);
   gtl_bus_side gtl_bus_side_i (.*);
   always #50 CLK = ~CLK;
   // *****************
   // Bus tasks and checks
   // *****************
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [1:0] p;
      p = 2'h3;
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= {24'h000000, d};
      S_AXI_AWVALID <= 1'h1;
      S_AXI_WVALID <= 1'h1;
      // Each channel is released at the edge that takes it
      while (p != 2'h0)
      begin
         @(posedge CLK);
         if (S_AXI_AWREADY === 1'h1)
            p[1] = 1'h0;
         if (S_AXI_WREADY === 1'h1)
            p[0] = 1'h0;
         S_AXI_AWVALID <= p[1];
         S_AXI_WVALID <= p[0];
      end
      do @(posedge CLK); while (S_AXI_BVALID !== 1'h1);
      r = S_AXI_BRESP;
      repeat (3) @(posedge CLK); // Lets mode outputs settle
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] s);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'h1;
      do @(posedge CLK); while (S_AXI_ARREADY !== 1'h1);
      S_AXI_ARVALID <= 1'h0;
      do @(posedge CLK); while (S_AXI_RVALID !== 1'h1);
      d = S_AXI_RDATA[7:0];
      s = S_AXI_RRESP;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Hang guard and record of one-cycle pulses
   always @(posedge CLK)
   begin
      cyc++;
      if (!RST)
      begin
         n_trig += TRIGGER_PULSE_OUT;
         seen <= seen | {TALK_MATCH, LISTEN_MATCH, ADDR_STATUS_CHANGE_IRQ, FINISH_HS, RTL_PULSE,
            SEC_VALID, SEC_NOT_VALID, LTN_PULSE, LUN_PULSE};
      end
      if (cyc == 3000)
      begin
         n_mismatch++;
         final_report;
      end
   end
   // Main sequence: table rows, then power-on, modes, end-of-string, events
   initial
   begin
      repeat (10) @(posedge CLK);
      RST <= 1'h0;
      @(posedge CLK);
      chk(PON, 1'h1);
      foreach (rows[i])
      begin
         wr(rows[i][31:24], rows[i][23:16]);
         rd(rows[i][15:8], q, r);
         chk(q, rows[i][7:0]);
      end
      wr(8'h14, 8'h00);
      chk(PON, 1'h0);
      wr(8'h14, 8'h02);
      rd(8'h18, q, r);
      chk({PON, q}, 9'h100);
      wr(8'h14, 8'h00);
      wr(8'h14, 8'hC3);
      chk({DAC_HOLD_GET, DAC_HOLD_DCL}, 2'h3);
      wr(8'h14, 8'h6A);
      wr(8'h14, 8'h09);
      chk(PP_RESPONSE, 8'h04);
      wr(8'h14, 8'hB7);
      chk({PP_RESPONSE, UNKNOWN_PASS, SPOLL_END, T1_SETTLE_CYCLES}, 14'h0035);
      wr(8'h1C, 8'h8A);
      wr(8'h14, 8'h86);
      gtl_bus_side_i.put_byte(8'h0A, 1'h1);
      @(posedge CLK);
      chk({EOS_END, HS_MODE}, 3'h6);
      rd(8'h1C, q, r);
      chk(q, 8'h80);
      wr(8'h14, 8'h96);
      gtl_bus_side_i.put_byte(8'h0A, 1'h0);
      @(posedge CLK);
      chk(EOS_END, 1'h0);
      rd(8'h14, q, r);
      chk(q, 8'hF5);
      gtl_bus_side_i.pulse_trigger;
      @(posedge CLK);
      chk(TRIGGER_PULSE_OUT, 1'h1);
      SPOLL_ENABLE_RX <= 1'h1;
      @(posedge CLK);
      SPOLL_ENABLE_RX <= 1'h0;
      rd(8'h10, q, r);
      chk(q, 8'h20);
      rd(8'h40, q, r);
      chk({r, q}, {RESP_SLVERR, 8'h00});
      // Serial poll clear beats enable; address events with two primaries
      {SPOLL_ENABLE_RX, SPOLL_DISABLE_RX} <= 2'h3;
      wr(8'h20, 8'h01);
      wr(8'h18, 8'h45);
      wr(8'h18, 8'h86);
      {SPOLL_ENABLE_RX, SPOLL_DISABLE_RX, LISTENER_ADDRESSED, LISTEN_PRIMARY, ADDR_RX, ADDR_RX_CODE} <= 10'h0E5;
      @(posedge CLK);
      ADDR_RX_LISTEN <= 1'h1;
      @(posedge CLK);
      {ADDR_RX_LISTEN, ADDR_RX_CODE} <= 6'h06;
      @(posedge CLK);
      ADDR_RX <= 1'h0;
      rd(8'h10, q, r);
      chk(q, 8'h15);
      chk(seen, 9'h1C0);
      // Immediate commands, poll setup and register A
      {TACS_STATE, SRQS_STATE} <= 2'h3;
      foreach (cmds[i])
         wr(8'h14, cmds[i]);
      chk(seen, 9'h1FF);
      chk(n_trig, 2);
      chk({RTL_MSG, SEND_EOI_NEXT, HS_MODE, EOS_SEND_EOI, IST_MSG, PP_RESPONSE}, 14'h3F04);
      {LIDS_STATE, BYTE_OUT_WR} <= 2'h3;
      @(posedge CLK);
      {LIDS_STATE, BYTE_OUT_WR} <= 2'h0;
      repeat (2) @(posedge CLK);
      chk({SEND_EOI_NEXT, HS_MODE}, 3'h2);
      wr(8'h40, 8'h00);
      chk(r, RESP_SLVERR);
      // Reset in mid-run
      RST <= 1'h1;
      @(posedge CLK);
      RST <= 1'h0;
      @(posedge CLK);
      chk({PON, HS_MODE, RTL_MSG, DAC_HOLD_DCL, S_AXI_AWREADY}, 6'h21);
      final_report;
   end
endmodule // tb_gpib_talker_listener_regs
